//--- verilog/fcs_pkg.sv
/*
  Shared constants for the flash command and status host controller:
  register map, field positions, bus-cycle timing and flash status bits.
  Assumes a 25 MHz system clock and one parallel NOR flash on the pins.
*/
`default_nettype none

package fcs_pkg;

  // Timing
  localparam int CLK_NS = 40;
  // Least strobe low time, rounded up to whole cycles
  localparam int STROBE_NS = 80;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);

  // Widths
  localparam int AW = 20;
  localparam int DW = 16;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;

  // Field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAIL = 1;
  localparam int STAT_RDY = 2;
  localparam int STAT_DONE = 3;

  // Flash status bits on the data bus
  localparam int POLL_BIT = 7;
  localparam int TOG1_BIT = 6;
  localparam int TIMEOUT_BIT = 5;

  // Values
  localparam logic [15:0] RESET_CMD = 16'h00F0;
  localparam logic [19:0] ADDR_RST = 20'h00000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    OP_WRITE = 2'b00,
    OP_READ = 2'b01,
    OP_TPOLL = 2'b10,
    OP_DPOLL = 2'b11
  } fcs_op_e;

endpackage

`default_nettype wire

//--- verilog/fcs_cycle.sv
/*
  One flash bus cycle (read or write) on the parallel pins.
  Assumes the flash latches address on the later falling strobe and data
  on the earlier rising strobe; inputs are synchronous to i_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module fcs_cycle
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [fcs_pkg::AW-1:0] i_addr,
  input wire logic [fcs_pkg::DW-1:0] i_wdata,
  input wire logic [fcs_pkg::DW-1:0] i_dq,
  output logic o_done,
  output logic [fcs_pkg::DW-1:0] o_rdata,
  output logic [fcs_pkg::AW-1:0] o_addr,
  output logic [fcs_pkg::DW-1:0] o_dq,
  output logic o_dq_oe_n,
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n
);
  import fcs_pkg::*;

  typedef enum logic [1:0]
  {
    C_IDLE = 2'b00,
    C_SETUP = 2'b01,
    C_STRB = 2'b10,
    C_HOLD = 2'b11
  } fcs_cyc_e;

  typedef struct packed {
    fcs_cyc_e st;
    logic [3:0] cnt;
    logic wr;
    logic done;
    logic [DW-1:0] rdata;
    logic [AW-1:0] addr;
    logic [DW-1:0] dq;
    logic dq_oe_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } fcs_cyc_s;

  fcs_cyc_s cur_ff;
  fcs_cyc_s nxt_cur;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    case (cur_ff.st)
      C_IDLE:
      begin
        if (i_start)
        begin
          // Address and data settle a full cycle before write or output enable falls; chip select falls with them
          nxt_cur.addr = i_addr;
          nxt_cur.wr = i_write;
          nxt_cur.dq = i_wdata;
          nxt_cur.dq_oe_n = ~i_write;
          nxt_cur.ce_n = 1'b0;
          nxt_cur.st = C_SETUP;
        end
      end
      C_SETUP:
      begin
        nxt_cur.we_n = ~cur_ff.wr;
        nxt_cur.oe_n = cur_ff.wr;
        nxt_cur.cnt = STROBE_CYC - 4'h1;
        nxt_cur.st = C_STRB;
      end
      C_STRB:
      begin
        if (cur_ff.cnt == 4'h0)
        begin
          // Sample while output enable is still low
          if (!cur_ff.wr)
          begin
            nxt_cur.rdata = i_dq;
          end
          nxt_cur.we_n = 1'b1;
          nxt_cur.oe_n = 1'b1;
          nxt_cur.st = C_HOLD;
        end
        else
        begin
          nxt_cur.cnt = cur_ff.cnt - 4'h1;
        end
      end
      C_HOLD:
      begin
        // Data held through the strobe rise, released with chip select
        nxt_cur.ce_n = 1'b1;
        nxt_cur.dq_oe_n = 1'b1;
        nxt_cur.done = 1'b1;
        nxt_cur.st = C_IDLE;
      end
      default:
      begin
        nxt_cur.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cur_ff <= '{st: C_IDLE, cnt: 4'h0, wr: 1'b0, done: 1'b0,
                 rdata: DATA_RST, addr: ADDR_RST, dq: DATA_RST,
                 dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_done = cur_ff.done;
  assign o_rdata = cur_ff.rdata;
  assign o_addr = cur_ff.addr;
  assign o_dq = cur_ff.dq;
  assign o_dq_oe_n = cur_ff.dq_oe_n;
  assign o_ce_n = cur_ff.ce_n;
  assign o_we_n = cur_ff.we_n;
  assign o_oe_n = cur_ff.oe_n;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_WE_DRIVES_DQ: assert property (
    !o_we_n |-> (!o_dq_oe_n && o_oe_n && !o_ce_n))
    else $error("write strobe without data drive or with read strobe");
  AST_STROBE_LEN: assert property (
    $fell(o_we_n) |-> (!o_we_n) [*2] ##1 o_we_n ##1 o_ce_n)
    else $error("write strobe width or release order wrong");

endmodule

`default_nettype wire

//--- verilog/fcs_host.sv
/*
  Host controller for a parallel NOR flash: software orders single bus
  cycles or a status poll through AXI4-Lite registers; the poll follows
  the toggle or polling-bit algorithm and ends in a clean data read, or in a reset command write on timeout.
  Assumes one flash on the pins and an external pull-up on ready/busy.
*/
// Contract
// - Host issues command cycles as writes
// - Only reset leaves ID or timeout state
// - Host gives bank address on ID read
// - Bypass program only after bypass entry
// - Host polls bit 7 at program address
// - Erase polls low, high when done; sector address
// - Host rereads after bit 7 shows data
`timescale 1ns/1ps
`default_nettype none

module fcs_host
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [fcs_pkg::AW-1:0] o_flash_addr,
  input wire logic [fcs_pkg::DW-1:0] i_flash_dq,
  output logic [fcs_pkg::DW-1:0] o_flash_dq,
  output logic o_flash_dq_oe_n,
  output logic o_flash_ce_n,
  output logic o_flash_we_n,
  output logic o_flash_oe_n,
  input wire logic i_ready_busy_out
);
  import fcs_pkg::*;

  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_SINGLE = 3'b001,
    S_RD1 = 3'b010,
    S_RD2 = 3'b011,
    S_RECHK = 3'b100,
    S_FINAL = 3'b101,
    S_RESET = 3'b110
  } fcs_seq_e;

  typedef struct packed {
    fcs_seq_e st;
    fcs_op_e op;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] first;
    logic [DW-1:0] rdata;
    logic busy;
    logic fail;
    logic done;
    logic go;
    logic wait_e;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rd;
  } fcs_host_s;

  fcs_host_s cur_ff;
  fcs_host_s nxt_cur;
  logic e_done;
  logic [DW-1:0] e_rdata;
  logic e_write;
  logic [DW-1:0] e_wdata;

  // Byte-lane merge for partial register writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset cycle after a failed poll, otherwise the ordered cycle
  assign e_write = (cur_ff.st == S_RESET) ||
                   (cur_ff.st == S_SINGLE && cur_ff.op == OP_WRITE);
  assign e_wdata = (cur_ff.st == S_RESET) ? RESET_CMD : cur_ff.wdata;

  fcs_cycle u_cycle
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_start(cur_ff.go),
    .i_write(e_write),
    .i_addr(cur_ff.addr),
    .i_wdata(e_wdata),
    .i_dq(i_flash_dq),
    .o_done(e_done),
    .o_rdata(e_rdata),
    .o_addr(o_flash_addr),
    .o_dq(o_flash_dq),
    .o_dq_oe_n(o_flash_dq_oe_n),
    .o_ce_n(o_flash_ce_n),
    .o_we_n(o_flash_we_n),
    .o_oe_n(o_flash_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [31:0] wv;
    logic [31:0] av;
    logic [31:0] dv;
    wv = merge(32'h00000000, cur_ff.wd, cur_ff.ws);
    av = merge({12'h000, cur_ff.addr}, cur_ff.wd, cur_ff.ws);
    dv = merge({16'h0000, cur_ff.wdata}, cur_ff.wd, cur_ff.ws);
    nxt_cur = cur_ff;
    nxt_cur.go = 1'b0;

    // Write channel: address and data taken in either order
    if (i_awvalid && cur_ff.awready)
    begin
      nxt_cur.aw_have = 1'b1;
      nxt_cur.awaddr = i_awaddr;
    end
    if (i_wvalid && cur_ff.wready)
    begin
      nxt_cur.w_have = 1'b1;
      nxt_cur.wd = i_wdata;
      nxt_cur.ws = i_wstrb;
    end
    if (cur_ff.bvalid && i_bready)
    begin
      nxt_cur.bvalid = 1'b0;
    end
    if (cur_ff.aw_have && cur_ff.w_have)
    begin
      nxt_cur.aw_have = 1'b0;
      nxt_cur.w_have = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp = RESP_OKAY;
      case (cur_ff.awaddr)
        OFF_CTRL:
        begin
          // Orders while busy are dropped to keep the sequence intact
          if (wv[CTRL_GO] && !cur_ff.busy)
          begin
            nxt_cur.op = fcs_op_e'(wv[CTRL_OP_LSB +: 2]);
            nxt_cur.busy = 1'b1;
            nxt_cur.fail = 1'b0;
            nxt_cur.done = 1'b0;
            nxt_cur.st = (wv[CTRL_OP_LSB +: 2] == OP_WRITE ||
                          wv[CTRL_OP_LSB +: 2] == OP_READ) ? S_SINGLE : S_RD1;
          end
        end
        OFF_ADDR:
        begin
          if (!cur_ff.busy)
          begin
            nxt_cur.addr = av[AW-1:0];
          end
        end
        OFF_WDATA:
        begin
          if (!cur_ff.busy)
          begin
            nxt_cur.wdata = dv[DW-1:0];
          end
        end
        OFF_STATUS, OFF_RDATA: ;
        default: nxt_cur.bresp = RESP_SLVERR;
      endcase
    end
    nxt_cur.awready = !nxt_cur.aw_have && !nxt_cur.bvalid;
    nxt_cur.wready = !nxt_cur.w_have && !nxt_cur.bvalid;

    // Read channel
    if (cur_ff.rvalid && i_rready)
    begin
      nxt_cur.rvalid = 1'b0;
    end
    if (i_arvalid && cur_ff.arready)
    begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp = RESP_OKAY;
      nxt_cur.rd = 32'h00000000;
      case (i_araddr)
        OFF_CTRL: nxt_cur.rd[CTRL_OP_LSB +: 2] = cur_ff.op;
        OFF_ADDR: nxt_cur.rd[AW-1:0] = cur_ff.addr;
        OFF_WDATA: nxt_cur.rd[DW-1:0] = cur_ff.wdata;
        OFF_STATUS:
        begin
          nxt_cur.rd[STAT_BUSY] = cur_ff.busy;
          nxt_cur.rd[STAT_FAIL] = cur_ff.fail;
          nxt_cur.rd[STAT_RDY] = i_ready_busy_out;
          nxt_cur.rd[STAT_DONE] = cur_ff.done;
        end
        OFF_RDATA: nxt_cur.rd[DW-1:0] = cur_ff.rdata;
        default: nxt_cur.rresp = RESP_SLVERR;
      endcase
    end
    nxt_cur.arready = !nxt_cur.rvalid;

    // Flash sequencer: one bus cycle per state visit
    if (cur_ff.st != S_IDLE && !cur_ff.wait_e)
    begin
      nxt_cur.go = 1'b1;
      nxt_cur.wait_e = 1'b1;
    end
    else if (cur_ff.wait_e && e_done)
    begin
      nxt_cur.wait_e = 1'b0;
      case (cur_ff.st)
        S_SINGLE:
        begin
          nxt_cur.rdata = e_rdata;
          nxt_cur.busy = 1'b0;
          nxt_cur.done = 1'b1;
          nxt_cur.st = S_IDLE;
        end
        S_RD1:
        begin
          nxt_cur.first = e_rdata;
          if (cur_ff.op == OP_TPOLL)
          begin
            nxt_cur.st = S_RD2;
          end
          else if (e_rdata[POLL_BIT] == cur_ff.wdata[POLL_BIT])
          begin
            nxt_cur.st = S_FINAL;
          end
          else if (e_rdata[TIMEOUT_BIT])
          begin
            nxt_cur.st = S_RECHK;
          end
        end
        S_RD2:
        begin
          nxt_cur.first = e_rdata;
          if (e_rdata[TOG1_BIT] == cur_ff.first[TOG1_BIT])
          begin
            nxt_cur.st = S_FINAL;
          end
          else if (e_rdata[TIMEOUT_BIT])
          begin
            nxt_cur.st = S_RECHK;
          end
        end
        S_RECHK:
        begin
          // Status may settle just as the timeout bit rises
          if ((cur_ff.op == OP_TPOLL &&
               e_rdata[TOG1_BIT] == cur_ff.first[TOG1_BIT]) ||
              (cur_ff.op == OP_DPOLL &&
               e_rdata[POLL_BIT] == cur_ff.wdata[POLL_BIT]))
          begin
            nxt_cur.st = S_FINAL;
          end
          else
          begin
            nxt_cur.st = S_RESET;
          end
        end
        S_FINAL:
        begin
          // Extra read: low bits may lag bit 7 at completion
          nxt_cur.rdata = e_rdata;
          nxt_cur.busy = 1'b0;
          nxt_cur.done = 1'b1;
          nxt_cur.st = S_IDLE;
        end
        S_RESET:
        begin
          nxt_cur.busy = 1'b0;
          nxt_cur.fail = 1'b1;
          nxt_cur.done = 1'b1;
          nxt_cur.st = S_IDLE;
        end
        default: nxt_cur.st = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cur_ff <= '{st: S_IDLE, op: OP_WRITE, addr: ADDR_RST,
                 wdata: DATA_RST, first: DATA_RST, rdata: DATA_RST,
                 awready: 1'b1, wready: 1'b1, arready: 1'b1,
                 awaddr: 8'h00, wd: 32'h00000000, ws: 4'h0,
                 bresp: RESP_OKAY, rresp: RESP_OKAY, rd: 32'h00000000,
                 default: 1'b0};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign o_awready = cur_ff.awready;
  assign o_wready = cur_ff.wready;
  assign o_bvalid = cur_ff.bvalid;
  assign o_bresp = cur_ff.bresp;
  assign o_arready = cur_ff.arready;
  assign o_rvalid = cur_ff.rvalid;
  assign o_rresp = cur_ff.rresp;
  assign o_rdata = cur_ff.rd;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_RESET_CMD: assert property (
    (cur_ff.go && cur_ff.st == S_RESET) |=>
    ##1 (!o_flash_we_n && o_flash_dq == RESET_CMD))
    else $error("recovery cycle is not a reset command write");
  AST_FAIL_AFTER_RESET: assert property (
    $rose(cur_ff.fail) |-> $past(cur_ff.st) == S_RESET)
    else $error("fail flag without a reset command");
  AST_POLL_ADDR: assert property (
    cur_ff.go |=> o_flash_addr == $past(cur_ff.addr))
    else $error("bus cycle not at ordered address");
  AST_SINGLE_WRITE: assert property (
    (cur_ff.go && cur_ff.st == S_SINGLE && cur_ff.op == OP_WRITE) |=>
    ##1 (!o_flash_we_n && o_flash_dq == $past(cur_ff.wdata, 2)))
    else $error("ordered write cycle carries wrong data");
  AST_DPOLL_MATCH: assert property (
    (cur_ff.st == S_RD1 && e_done && cur_ff.wait_e &&
     cur_ff.op == OP_DPOLL &&
     e_rdata[POLL_BIT] == cur_ff.wdata[POLL_BIT]) |=> cur_ff.st == S_FINAL)
    else $error("polling bit match not followed by final read");
  AST_DPOLL_WAIT: assert property (
    (cur_ff.st == S_RD1 && e_done && cur_ff.wait_e &&
     cur_ff.op == OP_DPOLL && e_rdata[POLL_BIT] != cur_ff.wdata[POLL_BIT] &&
     !e_rdata[TIMEOUT_BIT]) |=> (cur_ff.st == S_RD1 && !cur_ff.done))
    else $error("poll ended while polling bit still busy");
  AST_FINAL_READ: assert property (
    (cur_ff.done && !$past(cur_ff.done) && cur_ff.op[1] && !cur_ff.fail) |->
    $past(cur_ff.st) == S_FINAL)
    else $error("poll finished without a trailing data read");
  AST_B_HOLD: assert property (
    (cur_ff.bvalid && !i_bready) |=> cur_ff.bvalid)
    else $error("write response dropped before accepted");

  COV_WRITE: cover property (cur_ff.go && cur_ff.st == S_SINGLE && e_write);
  COV_TPOLL_OK: cover property (cur_ff.st == S_FINAL && cur_ff.op == OP_TPOLL);
  COV_FAIL: cover property ($rose(cur_ff.fail));
  COV_DPOLL_OK: cover property (cur_ff.st == S_FINAL && cur_ff.op == OP_DPOLL);

endmodule

`default_nettype wire

//--- bench/fcs_flash_model.sv
/*
  Behavioural flash partner: program command decode, status bits and
  the open-drain busy pin. Assumes the host strobes as on real pins;
  i_clk only times the internal program operation.
*/
`timescale 1ns/1ps
`default_nettype none

module fcs_flash_model
#(
  parameter int FAIL_CYC = 40
)
(
  input wire logic i_clk,
  input wire logic [19:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [7:0] i_busy_len,
  input wire logic i_stall,
  output logic [15:0] o_dq,
  output logic o_drive,
  output logic o_rb_low
);
  logic [15:0] mem [0:255];
  logic [19:0] lat_addr = 20'h00000;
  // Sector that refuses programming, and its status time (1 us)
  localparam logic [7:0] LOCK_SECT = 8'h0A;
  localparam int LOCK_CYC = 25;
  logic prog_bit7 = 1'b0;
  logic tog = 1'b0;
  logic tout = 1'b0;
  logic armed = 1'b0;
  int unlock = 0;
  int busy_cnt = 0;
  int hang = 0;
  wire logic wr_n = i_we_n | i_ce_n;
  wire logic rd_n = i_oe_n | i_ce_n;
  wire logic busy = busy_cnt > 0;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 16'hFFFF;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(negedge wr_n)
  begin
    lat_addr = i_addr;
  end

  always @(posedge wr_n)
  begin
    if (busy)
    begin
      // Only a reset leaves the failed state
      if (tout && i_dq[7:0] == 8'hF0)
      begin
        busy_cnt = 0;
        tout = 1'b0;
      end
    end
    else if (armed)
    begin
      // Locked sector keeps its data but still reports status a while
      if (lat_addr[19:12] != LOCK_SECT)
        mem[lat_addr[7:0]] = i_dq;
      prog_bit7 = i_dq[7];
      busy_cnt = (lat_addr[19:12] == LOCK_SECT) ? LOCK_CYC :
                 int'(i_busy_len);
      hang = 0;
      armed = 1'b0;
    end
    else if (unlock == 0 && lat_addr[10:0] == 11'h555 && i_dq[7:0] == 8'hAA)
      unlock = 1;
    else if (unlock == 1 && lat_addr[10:0] == 11'h2AA && i_dq[7:0] == 8'h55)
      unlock = 2;
    else if (unlock == 2 && lat_addr[10:0] == 11'h555 && i_dq[7:0] == 8'hA0)
    begin
      unlock = 0;
      armed = 1'b1;
    end
    else
      unlock = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Counted on the falling edge so the count never runs out at a sampling edge
  always @(negedge i_clk)
  begin
    if (busy && !i_stall)
      busy_cnt = busy_cnt - 1;
    else if (busy && !tout)
    begin
      hang = hang + 1;
      tout = (hang >= FAIL_CYC);
    end
  end

  always @(posedge rd_n)
  begin
    if (busy)
      tog = ~tog;
  end

  assign o_drive = !rd_n;
  assign o_rb_low = busy;
  assign o_dq = busy ? {8'h00, ~prog_bit7, tog, tout, 5'h00} :
                mem[i_addr[7:0]];
endmodule

`default_nettype wire

//--- bench/tb_flash_command_status_reporting.sv
/*
  Self-checking bench for the flash host controller: AXI4-Lite register
  tasks run bus-cycle, poll and failure scenarios against a flash model.
  Assumes fcs_pkg and the flash model in bench/.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_flash_command_status_reporting;
  import fcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] busy_len = 8'h01;
  logic stall = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [19:0] f_addr;
  logic [15:0] f_dq, m_dq;
  logic f_oe_n, f_ce_n, f_we_n, f_rd_n, m_drive, m_rb_low;
  int bad_count = 0;
  int total_checks = 0;
  // Floating bus shows a changing pattern, never the last value
  wire logic [15:0] dq_bus = !f_oe_n ? f_dq :
    m_drive ? m_dq : ({16{clk}} ^ 16'h5A5A);

  always #20 clk = ~clk;

  fcs_host uut (.i_clk(clk), .i_reset(rst), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_flash_addr(f_addr), .i_flash_dq(dq_bus), .o_flash_dq(f_dq),
    .o_flash_dq_oe_n(f_oe_n), .o_flash_ce_n(f_ce_n),
    .o_flash_we_n(f_we_n), .o_flash_oe_n(f_rd_n),
    .i_ready_busy_out(!m_rb_low));

  fcs_flash_model fm (.i_clk(clk), .i_addr(f_addr), .i_dq(dq_bus),
    .i_ce_n(f_ce_n), .i_we_n(f_we_n), .i_oe_n(f_rd_n),
    .i_busy_len(busy_len), .i_stall(stall), .o_dq(m_dq),
    .o_drive(m_drive), .o_rb_low(m_rb_low));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
      end
    end while (bvalid !== 1'b1);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    d = 32'h0;
    r = 2'h3;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end while (rvalid !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic start_op(input logic [1:0] op, input logic [19:0] a,
    input logic [15:0] d);
    wr(OFF_ADDR, {12'h000, a});
    wr(OFF_WDATA, {16'h0000, d});
    wr(OFF_CTRL, {29'h0, op, 1'b1});
  endtask

  // Only the watchdog ends a poll that never finishes
  task automatic wait_done;
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h0;
    while (!(d[STAT_DONE] === 1'b1 && d[STAT_BUSY] === 1'b0))
    begin
      axi_rd(OFF_STATUS, d, r);
    end
  endtask

  task automatic run_op(input logic [1:0] op, input logic [19:0] a,
    input logic [15:0] d);
    start_op(op, a, d);
    wait_done;
  endtask

  // Upper address and data bits carry junk the flash must ignore
  task automatic prog(input logic [19:0] program_address,
    input logic [15:0] program_value);
    run_op(2'h0, 20'hFF555, 16'hABAA);
    run_op(2'h0, 20'hFF2AA, 16'h1255);
    run_op(2'h0, 20'hFF555, 16'h34A0);
    run_op(2'h0, program_address, program_value);
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(40 * 40000);
    bad_count++;
    conclude;
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFF_STATUS, 32'h4);
    rd_chk(OFF_CTRL, 32'h0);
    rd_chk(OFF_RDATA, 32'h0);
    axi_wr(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    // Slow flash: toggle then data poll, with a refused address write during the toggle poll
    busy_len <= 8'h96;
    prog(20'hFF012, 16'hC35A);
    rd_chk(OFF_STATUS, 32'h8);
    start_op(2'h2, 20'h00012, 16'h0000);
    wr(OFF_ADDR, 32'h00055);
    rd_chk(OFF_ADDR, 32'h00012);
    wait_done;
    rd_chk(OFF_STATUS, 32'hC);
    rd_chk(OFF_RDATA, 32'hC35A);
    chk({16'h0, fm.mem[8'h12]}, 32'hC35A);
    prog(20'h00077, 16'h1280);
    run_op(2'h3, 20'h00077, 16'h1280);
    rd_chk(OFF_STATUS, 32'hC);
    rd_chk(OFF_RDATA, 32'h1280);
    // Prompt flash, then plain read cycles
    busy_len <= 8'h01;
    prog(20'h00033, 16'h00FF);
    run_op(2'h2, 20'h00033, 16'h0000);
    rd_chk(OFF_RDATA, 32'h00FF);
    run_op(2'h1, 20'h00099, 16'h0000);
    rd_chk(OFF_RDATA, 32'hFFFF);
    // Locked sector: status for a while, data left erased
    prog(20'h0A0EE, 16'h1234);
    run_op(2'h2, 20'h0A0EE, 16'h0000);
    rd_chk(OFF_STATUS, 32'hC);
    rd_chk(OFF_RDATA, 32'hFFFF);
    chk({16'h0, fm.mem[8'hEE]}, 32'hFFFF);
    // Stalled program: both polls end in timeout and reset
    stall <= 1'b1;
    for (int k = 2; k < 4; k++)
    begin
      prog(20'h00044, 16'h0055);
      run_op(k[1:0], 20'h00044, 16'h0055);
      rd_chk(OFF_STATUS, 32'hE);
      chk({31'h0, fm.tout}, 32'h0);
    end
    stall <= 1'b0;
    conclude;
  end
endmodule

`default_nettype wire
